//--- src/mrsd_pkg.sv
// shared constants and types for the mapper register space decoder
package mrsd_pkg;
  // ==========================================================
  // bus widths and section layout
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int SECT_LSB = 6;
  localparam logic [3:0] SECT_GLOBAL = 4'h0;
  localparam logic [3:0] SECT_ARBITER = 4'h1;
  localparam logic [11:0] MAP_TOP = 12'h8ff;
  localparam logic [9:0] SERIAL_LO = 10'h0c0;
  localparam logic [9:0] SERIAL_HI = 10'h13f;
  localparam logic [9:0] ETH_LO = 10'h140;
  localparam logic [9:0] ETH_HI = 10'h17f;
  localparam logic [7:0] BERT_LO = 8'hdb;
  localparam logic [7:0] BERT_HI = 8'hef;

  // ==========================================================
  // read-only and read-to-clear offsets, with their live bits
  localparam logic [9:0] OFF_IDENT_LOW = 10'h000;
  localparam logic [9:0] OFF_IDENT_HIGH = 10'h001;
  localparam logic [9:0] OFF_LINE_IRQ_STATUS = 10'h007;
  localparam logic [9:0] OFF_SUBSCRIBER_IRQ_STATUS = 10'h009;
  localparam logic [9:0] OFF_QUEUE_IRQ_STATUS = 10'h00b;
  localparam logic [9:0] OFF_BERT_IMUX_IRQ_STATUS = 10'h00d;
  localparam logic [9:0] OFF_INVMUX_SYNC_STATUS = 10'h018;
  localparam logic [9:0] OFF_SELFTEST_RESULT = 10'h021;
  localparam logic [7:0] MASK_LINE_IRQ = 8'h11;
  localparam logic [7:0] MASK_SUBSCRIBER_IRQ = 8'h01;
  localparam logic [7:0] MASK_QUEUE_IRQ = 8'h11;
  localparam logic [7:0] MASK_BERT_IMUX_IRQ = 8'h03;
  localparam logic [7:0] MASK_SELFTEST = 8'h03;
  // latched slots: 0 sync, 1 delay error, 2 out of frame
  localparam int NLAT = 3;
  localparam logic [NLAT-1:0][9:0] LAT_ADDR = {10'h01f, 10'h01d, 10'h01a};
  localparam logic [NLAT-1:0][7:0] LAT_MASK = {8'hff, 8'h01, 8'hff};

  // ==========================================================
  // read/write registers, slot 0 last in each list; all reset to zero
  localparam int NRW = 23;
  localparam logic [NRW-1:0][9:0] RW_ADDR = {
    10'h041, 10'h040, 10'h03d, 10'h03c, 10'h03b, 10'h03a, 10'h038, 10'h020,
    10'h01e, 10'h01c, 10'h01b, 10'h019, 10'h017, 10'h016, 10'h012, 10'h00e,
    10'h00c, 10'h00a, 10'h008, 10'h006, 10'h005, 10'h004, 10'h002};
  localparam logic [NRW-1:0][7:0] RW_MASK = {
    8'hff, 8'hff, 8'hff, 8'h01, 8'h07, 8'h0f, 8'h3f, 8'h01,
    8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h0f, 8'h01,
    8'h03, 8'h11, 8'h01, 8'h11, 8'h03, 8'h11, 8'h07};
  localparam logic [7:0] RW_RESET = 8'h00;
  localparam int SLOT_GLOBAL_CONTROL = 0;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_INTERRUPT_MASK_BIT = 1;
  localparam int CTRL_REFCLK_OUT_BIT = 2;

  // ==========================================================
  // forwarded space and register state
  typedef enum logic [1:0] {FWD_SERIAL, FWD_ETHERNET, FWD_XCVR} mrsd_space_e;

  typedef struct packed {
    logic [NRW-1:0][7:0] rw;
    logic [NLAT-1:0][7:0] lat;
    logic [7:0] rdata;
    logic rd_valid;
    logic fwd_rd;
    logic fwd_wr;
    mrsd_space_e fwd_space;
    logic [1:0] fwd_port;
    logic fwd_bert;
    logic [7:0] fwd_offset;
    logic [7:0] fwd_wdata;
  } mrsd_state_s;
endpackage

//--- src/mrsd_decode.sv
// register space, host address decode and latched status for the mapper
`timescale 1ns/10ps

module mrsd_decode
  #(
    parameter logic [15:0] IDENT_CODE = 16'h5a3c // arbitrary value
  )
  (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // host register port
    input wire logic [mrsd_pkg::ADDR_W-1:0] host_addr,
    input wire logic [mrsd_pkg::DATA_W-1:0] host_wdata,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic mapper_select_n,
    input wire logic transceiver_select_n,
    output logic [mrsd_pkg::DATA_W-1:0] host_rdata_q,
    output logic host_rd_valid_q,
    // forwarded access to serial, ethernet and transceiver logic
    input wire logic [mrsd_pkg::DATA_W-1:0] fwd_rdata,
    output logic fwd_rd_q,
    output logic fwd_wr_q,
    output mrsd_pkg::mrsd_space_e fwd_space_q,
    output logic [1:0] fwd_port_q,
    output logic fwd_bert_q,
    output logic [7:0] fwd_offset_q,
    output logic [mrsd_pkg::DATA_W-1:0] fwd_wdata_q,
    // live status from the rest of the chip
    input wire logic [7:0] line_irq_status_in,
    input wire logic [7:0] subscriber_irq_status_in,
    input wire logic [7:0] queue_irq_status_in,
    input wire logic [7:0] bert_imux_irq_status_in,
    input wire logic [7:0] invmux_sync_status_in,
    input wire logic [7:0] selftest_result_in,
    // one-cycle events that feed latched status
    input wire logic [7:0] sync_event,
    input wire logic delay_err_event,
    input wire logic [7:0] oof_event,
    // configuration out
    output logic soft_reset_q,
    output logic interrupt_mask_bit_q,
    output logic refclk_output_enable_q,
    output logic [mrsd_pkg::NRW*mrsd_pkg::DATA_W-1:0] cfg_bank_q
  );
  import mrsd_pkg::*;

  // ==========================================================
  // address decode
  mrsd_state_s s_q;
  mrsd_state_s s_d;
  logic map_sel;
  logic xcvr_sel;
  logic [3:0] sect;
  logic in_range;
  logic in_global;
  logic in_serial;
  logic in_eth;
  logic is_bert;
  logic fwd_hit;
  logic rd_take;
  logic wr_take;
  logic [NRW-1:0] rw_hit;
  logic [NLAT-1:0] lat_hit;
  logic [NLAT-1:0][7:0] lat_ev;
  logic [9:0] off_full;
  logic [7:0] loc_rdata;

  // both selects low or both high decodes nothing; a read is still answered with zero
  assign map_sel = !mapper_select_n && transceiver_select_n;
  assign xcvr_sel = mapper_select_n && !transceiver_select_n;
  // section number is the bits above the 64-byte window
  assign sect = host_addr[ADDR_W-1:SECT_LSB];
  // ten lines never reach past the top, kept as a guard for a wider bus
  assign in_range = {2'b00, host_addr} <= MAP_TOP;
  assign in_global = map_sel && in_range && (sect == SECT_GLOBAL || sect == SECT_ARBITER);
  assign in_serial = map_sel && host_addr >= SERIAL_LO && host_addr <= SERIAL_HI;
  // only the mapper side of the ethernet port is visible here; mac space
  // stays behind the indirect access registers of that section
  assign in_eth = map_sel && host_addr >= ETH_LO && host_addr <= ETH_HI;
  assign is_bert = host_addr[7:0] >= BERT_LO && host_addr[7:0] <= BERT_HI;
  assign fwd_hit = in_serial || in_eth || xcvr_sel;

  // read wins when a careless host raises both strobes together
  assign rd_take = clk_en && host_rd;
  assign wr_take = clk_en && host_wr && !host_rd;

  // events grouped in the latched slot layout
  assign lat_ev[0] = sync_event;
  assign lat_ev[1] = {7'h00, delay_err_event};
  assign lat_ev[2] = oof_event;

  // ==========================================================
  // per-register match
  genvar gi;
  generate
    for (gi = 0; gi < NRW; gi++)
    begin : g_rw_hit
      assign rw_hit[gi] = in_global && host_addr == RW_ADDR[gi];
    end
    for (gi = 0; gi < NLAT; gi++)
    begin : g_lat_hit
      assign lat_hit[gi] = in_global && host_addr == LAT_ADDR[gi];
    end
  endgenerate

  // offset inside the forwarded space
  always_comb
  begin
    if (in_serial)
    begin
      off_full = host_addr - SERIAL_LO;
    end
    else if (in_eth)
    begin
      off_full = host_addr - ETH_LO;
    end
    else
    begin
      off_full = {2'b00, host_addr[7:0]};
    end
  end

  // ==========================================================
  // local read mux; anything unmatched reads zero
  always_comb
  begin
    loc_rdata = 8'h00;
    for (int i = 0; i < NRW; i++)
    begin
      if (rw_hit[i])
      begin
        loc_rdata = loc_rdata | (s_q.rw[i] & RW_MASK[i]);
      end
    end
    for (int j = 0; j < NLAT; j++)
    begin
      if (lat_hit[j])
      begin
        loc_rdata = loc_rdata | (s_q.lat[j] & LAT_MASK[j]);
      end
    end
    if (in_global)
    begin
      case (host_addr)
        OFF_IDENT_LOW: loc_rdata = IDENT_CODE[7:0];
        OFF_IDENT_HIGH: loc_rdata = IDENT_CODE[15:8];
        OFF_LINE_IRQ_STATUS: loc_rdata = line_irq_status_in & MASK_LINE_IRQ;
        OFF_SUBSCRIBER_IRQ_STATUS: loc_rdata = subscriber_irq_status_in & MASK_SUBSCRIBER_IRQ;
        OFF_QUEUE_IRQ_STATUS: loc_rdata = queue_irq_status_in & MASK_QUEUE_IRQ;
        OFF_BERT_IMUX_IRQ_STATUS: loc_rdata = bert_imux_irq_status_in & MASK_BERT_IMUX_IRQ;
        OFF_INVMUX_SYNC_STATUS: loc_rdata = invmux_sync_status_in;
        OFF_SELFTEST_RESULT: loc_rdata = selftest_result_in & MASK_SELFTEST;
        default: loc_rdata = loc_rdata;
      endcase
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    if (clk_en)
    begin
      // strobes to the host and forward side are single-cycle
      s_d.rd_valid = rd_take;
      s_d.fwd_rd = 1'b0;
      s_d.fwd_wr = 1'b0;
      if (rd_take)
      begin
        // forwarded spaces answer combinationally from the address
        s_d.rdata = fwd_hit ? fwd_rdata : loc_rdata;
      end
      // writes land only on decoded bits; reserved bits stay zero
      for (int i = 0; i < NRW; i++)
      begin
        if (wr_take && rw_hit[i])
        begin
          s_d.rw[i] = host_wdata & RW_MASK[i];
        end
      end
      if ((rd_take || wr_take) && fwd_hit)
      begin
        s_d.fwd_rd = rd_take;
        s_d.fwd_wr = wr_take;
        s_d.fwd_offset = off_full[7:0];
        s_d.fwd_wdata = host_wdata;
        s_d.fwd_port = host_addr[9:8];
        s_d.fwd_bert = xcvr_sel && is_bert;
        if (in_serial)
        begin
          s_d.fwd_space = FWD_SERIAL;
        end
        else if (in_eth)
        begin
          s_d.fwd_space = FWD_ETHERNET;
        end
        else
        begin
          s_d.fwd_space = FWD_XCVR;
        end
      end
      // latched status: a new event in the reading cycle survives the clear
      for (int j = 0; j < NLAT; j++)
      begin
        if (s_q.rw[SLOT_GLOBAL_CONTROL][CTRL_SOFT_RESET_BIT])
        begin
          s_d.lat[j] = 8'h00;
        end
        else if (rd_take && lat_hit[j])
        begin
          s_d.lat[j] = lat_ev[j] & LAT_MASK[j];
        end
        else
        begin
          s_d.lat[j] = s_q.lat[j] | (lat_ev[j] & LAT_MASK[j]);
        end
      end
    end
  end

  // state register; clk_en low freezes everything, pulses included
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.rw <= {NRW{RW_RESET}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign host_rdata_q = s_q.rdata;
  assign host_rd_valid_q = s_q.rd_valid;
  assign fwd_rd_q = s_q.fwd_rd;
  assign fwd_wr_q = s_q.fwd_wr;
  assign fwd_space_q = s_q.fwd_space;
  assign fwd_port_q = s_q.fwd_port;
  assign fwd_bert_q = s_q.fwd_bert;
  assign fwd_offset_q = s_q.fwd_offset;
  assign fwd_wdata_q = s_q.fwd_wdata;
  assign soft_reset_q = s_q.rw[SLOT_GLOBAL_CONTROL][CTRL_SOFT_RESET_BIT];
  assign interrupt_mask_bit_q = s_q.rw[SLOT_GLOBAL_CONTROL][CTRL_INTERRUPT_MASK_BIT];
  assign refclk_output_enable_q = s_q.rw[SLOT_GLOBAL_CONTROL][CTRL_REFCLK_OUT_BIT];
  assign cfg_bank_q = s_q.rw;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // a read with neither select alone active answers zero
  no_select_zero_a: assert property (
    (clk_en && host_rd && mapper_select_n == transceiver_select_n)
    |=> (host_rd_valid_q && host_rdata_q == 8'h00 && !fwd_rd_q))
    else $error("read without a single select did not return zero");

  // the gap section between arbiter and serial reads zero, no forward
  gap_section_a: assert property (
    (clk_en && host_rd && map_sel && host_addr[9:6] == 4'h2)
    |=> (host_rdata_q == 8'h00 && !fwd_rd_q))
    else $error("gap section access was not empty");

  // mapper addresses above the ethernet window are never forwarded
  range_top_a: assert property (
    (clk_en && (host_rd || host_wr) && map_sel && host_addr > 10'h17f)
    |=> (!fwd_rd_q && !fwd_wr_q))
    else $error("access beyond the mapper space was forwarded");

  // serial window goes to the serial side with the rebased offset
  serial_route_a: assert property (
    (clk_en && host_rd && map_sel && host_addr >= 10'h0c0 && host_addr <= 10'h13f)
    |=> (fwd_rd_q && fwd_space_q == FWD_SERIAL && fwd_offset_q == 8'(($past(host_addr) - 10'h0c0))))
    else $error("serial window read was not routed");

  // ethernet forwards stay in the 64-byte mapper window
  eth_window_a: assert property (
    (fwd_rd_q && fwd_space_q == FWD_ETHERNET && $past(clk_en))
    |-> ($past(host_addr) >= 10'h140 && $past(host_addr) <= 10'h17f))
    else $error("ethernet forward outside its window");

  // transceiver select picks port from the two top address bits
  xcvr_port_a: assert property (
    (clk_en && host_wr && !host_rd && xcvr_sel)
    ##1 fwd_wr_q |-> (fwd_space_q == FWD_XCVR && fwd_port_q == $past(host_addr[9:8])
      && fwd_bert_q == ($past(host_addr[7:0]) >= 8'hdb && $past(host_addr[7:0]) <= 8'hef)))
    else $error("transceiver port or bert flag wrong");

  // control write lands in the three control bits; the upper bits of that register stay zero
  ctrl_bits_a: assert property (
    (clk_en && host_wr && !host_rd && map_sel && host_addr == 10'h002)
    |=> (soft_reset_q == $past(host_wdata[0]) && interrupt_mask_bit_q == $past(host_wdata[1])
      && refclk_output_enable_q == $past(host_wdata[2]) && cfg_bank_q[7:3] == 5'h00))
    else $error("global control write mismatch");

  // a write to a reserved global address changes no register
  reserved_write_a: assert property (
    (clk_en && host_wr && map_sel && host_addr == 10'h003)
    |=> $stable(cfg_bank_q))
    else $error("reserved global write changed configuration");

  // an event sets its latched bit, which shows in the next cycle
  latch_set_a: assert property (
    (clk_en && sync_event[0] && !soft_reset_q)
    |=> s_q.lat[0][0])
    else $error("latched status did not set on event");

  // reading the latched register returns the old value, then clears it
  latch_clear_a: assert property (
    (clk_en && host_rd && map_sel && host_addr == 10'h01a && sync_event == 8'h00 && !soft_reset_q)
    |=> (host_rdata_q == $past(s_q.lat[0]) && s_q.lat[0] == 8'h00))
    else $error("latched status read did not clear");

  // with the clock enable low nothing moves
  freeze_a: assert property (
    (!clk_en) |=> $stable(s_q))
    else $error("state changed while clock enable was low");

  // every taken read is answered in the next cycle, whatever it decoded to
  read_answer_a: assert property (
    (clk_en && host_rd)
    |=> host_rd_valid_q)
    else $error("read was not answered in the next cycle");

  // the low ident byte comes from the identity parameter
  ident_low_a: assert property (
    (clk_en && host_rd && map_sel && host_addr == OFF_IDENT_LOW)
    |=> (host_rdata_q == IDENT_CODE[7:0]))
    else $error("ident low byte read mismatch");

  // line interrupt status reads show only the defined bits
  status_mask_a: assert property (
    (clk_en && host_rd && map_sel && host_addr == OFF_LINE_IRQ_STATUS)
    |=> (host_rdata_q == ($past(line_irq_status_in) & MASK_LINE_IRQ)))
    else $error("line status read not masked");

  // the arbiter section is decoded under the mapper select
  arbiter_write_a: assert property (
    (clk_en && host_wr && !host_rd && map_sel && host_addr == RW_ADDR[21])
    |=> (cfg_bank_q[8*21 +: 8] == $past(host_wdata)))
    else $error("arbiter write did not land");

  // a transceiver read is answered from the forwarded data only
  xcvr_read_a: assert property (
    (clk_en && host_rd && xcvr_sel)
    |=> (fwd_rd_q && fwd_space_q == FWD_XCVR && host_rdata_q == $past(fwd_rdata)))
    else $error("transceiver read not forwarded");

  // the transceiver select never reaches the mapper's own registers
  xcvr_no_local_a: assert property (
    (clk_en && host_wr && xcvr_sel)
    |=> $stable(cfg_bank_q))
    else $error("transceiver write changed mapper configuration");

endmodule // mrsd_decode

//--- dv/mrsd_host_model.sv
// host processor model that drives the mapper register port
`timescale 1ns/10ps

module mrsd_host_model
  (
    input wire logic ref_clk,
    input wire logic [mrsd_pkg::DATA_W-1:0] host_rdata_q,
    input wire logic host_rd_valid_q,
    output logic [mrsd_pkg::ADDR_W-1:0] host_addr,
    output logic [mrsd_pkg::DATA_W-1:0] host_wdata,
    output logic host_rd,
    output logic host_wr,
    output logic mapper_select_n,
    output logic transceiver_select_n
  );
  import mrsd_pkg::*;
  // ==========================================================
  // bus idle at time zero, no chip selected
  initial
  begin
    host_addr = 10'h000;
    host_wdata = 8'h00;
    host_rd = 1'b0;
    host_wr = 1'b0;
    mapper_select_n = 1'b1;
    transceiver_select_n = 1'b1;
  end
  // sel is {mapper_select_n, transceiver_select_n}; answer is looked at in the cycle after the taking edge
  task automatic access(input logic wr, input logic [1:0] sel, input logic [9:0] addr,
    input logic [7:0] wdata, output logic valid, output logic [7:0] rdata);
    @(posedge ref_clk);
    #1;
    {mapper_select_n, transceiver_select_n} = sel;
    host_addr = addr;
    host_wdata = wdata;
    host_rd = !wr;
    host_wr = wr;
    @(posedge ref_clk);
    #1;
    valid = host_rd_valid_q;
    rdata = host_rdata_q;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = ~wdata; // a released data bus must not keep showing the last value
    host_addr = ~addr;
  endtask
  // live marks the bits that hold a field; a caller passes all ones only to break the habit on purpose
  task automatic wr_reg(input logic [1:0] sel, input logic [9:0] addr, input logic [7:0] data,
    input logic [7:0] live);
    logic v;
    logic [7:0] d;
    access(1'b1, sel, addr, data & live, v, d);
  endtask
  task automatic rd_reg(input logic [1:0] sel, input logic [9:0] addr, input logic [7:0] live,
    output logic v, output logic [7:0] d);
    access(1'b0, sel, addr, 8'h00, v, d);
    d = d & live;
  endtask
  // zero every global place and the two arbiter registers once after reset
  task automatic init_zero();
    for (int a = 0; a < 7'h42; a++)
      wr_reg(2'b01, 10'(a), 8'h00, 8'hff);
  endtask
endmodule // mrsd_host_model

//--- dv/mapper_register_space_decode_tb_top.sv
// self-checking bench for the mapper register space decoder
`timescale 1ns/10ps

module mapper_register_space_decode_tb_top;
  import mrsd_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  localparam logic [9:0] RSV [7] = '{10'h003, 10'h00f, 10'h03f, 10'h080, 10'h0bf, 10'h180, 10'h3c2};
  localparam logic [7:0] XO [4] = '{8'hda, 8'hdb, 8'hef, 8'hf0};
  localparam logic [3:0] XB = 4'b0110;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] host_addr;
  logic [7:0] host_wdata, host_rdata_q, fwd_rdata, fwd_offset_q, fwd_wdata_q;
  logic host_rd, host_wr, msel_n, tsel_n, host_rd_valid_q, fwd_rd_q, fwd_wr_q, fwd_bert_q;
  logic soft_reset_q, interrupt_mask_bit_q, refclk_output_enable_q;
  logic [1:0] fwd_port_q;
  mrsd_space_e fwd_space_q;
  logic [NRW*DATA_W-1:0] cfg_bank_q;
  logic [7:0] stat = 8'h00;
  logic [7:0] sync_event = 8'h00;
  logic [7:0] oof_event = 8'h00;
  logic delay_err_event = 1'b0;
  logic clk_en = 1'b1;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;
  // far-side logic answers combinationally from the address
  assign fwd_rdata = host_addr[7:0] ^ 8'h3c;

  mrsd_decode #(.IDENT_CODE(16'hc35a)) dut ( // arbitrary value
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr),
    .mapper_select_n(msel_n), .transceiver_select_n(tsel_n),
    .host_rdata_q(host_rdata_q), .host_rd_valid_q(host_rd_valid_q), .fwd_rdata(fwd_rdata),
    .fwd_rd_q(fwd_rd_q), .fwd_wr_q(fwd_wr_q), .fwd_space_q(fwd_space_q), .fwd_port_q(fwd_port_q),
    .fwd_bert_q(fwd_bert_q), .fwd_offset_q(fwd_offset_q), .fwd_wdata_q(fwd_wdata_q),
    .line_irq_status_in(stat), .subscriber_irq_status_in(stat), .queue_irq_status_in(stat),
    .bert_imux_irq_status_in(stat), .invmux_sync_status_in(stat), .selftest_result_in(stat),
    .sync_event(sync_event), .delay_err_event(delay_err_event), .oof_event(oof_event),
    .soft_reset_q(soft_reset_q), .interrupt_mask_bit_q(interrupt_mask_bit_q),
    .refclk_output_enable_q(refclk_output_enable_q), .cfg_bank_q(cfg_bank_q));

  mrsd_host_model host (
    .ref_clk(ref_clk), .host_rdata_q(host_rdata_q), .host_rd_valid_q(host_rd_valid_q),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr),
    .mapper_select_n(msel_n), .transceiver_select_n(tsel_n));

  // ==========================================================
  // shared checks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_rd(input logic [1:0] sel, input logic [9:0] addr, input logic [7:0] exp);
    logic v;
    logic [7:0] d;
    host.rd_reg(sel, addr, 8'hff, v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  // one-cycle event pulse, launched just after an edge
  task automatic pulse(input logic [7:0] s, input logic d, input logic [7:0] o);
    @(posedge ref_clk);
    #1;
    {sync_event, delay_err_event, oof_event} = {s, d, o};
    @(posedge ref_clk);
    #1;
    {sync_event, delay_err_event, oof_event} = 17'h00000;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_ident();
    expect_rd(2'b01, 10'h000, 8'h5a);
    expect_rd(2'b01, 10'h001, 8'hc3);
    expect_rd(2'b01, 10'h002, 8'h00);
  endtask
  // every read/write place keeps its live bits only, seen on the bank and on read-back
  task automatic t_rw();
    for (int i = 0; i < NRW; i++)
    begin
      host.wr_reg(2'b01, RW_ADDR[i], 8'hff, 8'hff);
      chk(cfg_bank_q[8*i +: 8], RW_MASK[i]);
      expect_rd(2'b01, RW_ADDR[i], RW_MASK[i]);
      host.wr_reg(2'b01, RW_ADDR[i], 8'h00, 8'hff);
    end
  endtask
  task automatic t_ctrl();
    host.wr_reg(2'b01, 10'h002, 8'h06, 8'h07);
    chk({5'h00, refclk_output_enable_q, interrupt_mask_bit_q, soft_reset_q}, 8'h06);
    host.wr_reg(2'b01, 10'h002, 8'h01, 8'h07);
    chk({5'h00, refclk_output_enable_q, interrupt_mask_bit_q, soft_reset_q}, 8'h01);
  endtask
  // reserved and undecoded places, and both selects equal, leave no trace
  task automatic t_reserved();
    foreach (RSV[i])
    begin
      host.wr_reg(2'b01, RSV[i], 8'hff, 8'hff);
      chk({6'h00, fwd_rd_q, fwd_wr_q}, 8'h00);
      expect_rd(2'b01, RSV[i], 8'h00);
    end
    host.wr_reg(2'b00, 10'h004, 8'hff, 8'hff);
    host.wr_reg(2'b11, 10'h005, 8'hff, 8'hff);
    expect_rd(2'b01, 10'h004, 8'h00);
    expect_rd(2'b01, 10'h005, 8'h00);
    // a live register must still read zero when the selects are not one-hot
    host.wr_reg(2'b01, 10'h004, 8'h11, 8'h11);
    expect_rd(2'b00, 10'h004, 8'h00);
    expect_rd(2'b11, 10'h004, 8'h00);
    host.wr_reg(2'b01, 10'h004, 8'h00, 8'hff);
  endtask
  task automatic t_latched();
    host.wr_reg(2'b01, 10'h002, 8'h00, 8'h07);
    pulse(8'h81, 1'b1, 8'h10);
    expect_rd(2'b01, 10'h01a, 8'h81);
    expect_rd(2'b01, 10'h01a, 8'h00);
    expect_rd(2'b01, 10'h01d, 8'h01);
    // an event in the reading cycle survives the clear
    fork
      expect_rd(2'b01, 10'h01f, 8'h10);
      pulse(8'h00, 1'b0, 8'h04);
    join
    expect_rd(2'b01, 10'h01f, 8'h04);
    pulse(8'h02, 1'b0, 8'h00);
    host.wr_reg(2'b01, 10'h002, 8'h01, 8'h07);
    host.wr_reg(2'b01, 10'h002, 8'h00, 8'h07);
    expect_rd(2'b01, 10'h01a, 8'h00);
  endtask
  task automatic t_fwd();
    expect_rd(2'b01, 10'h0c5, 8'hf9);
    chk({fwd_rd_q, fwd_wr_q, 4'h0, fwd_space_q}, {2'b10, 4'h0, FWD_SERIAL});
    chk(fwd_offset_q, 8'h05);
    host.wr_reg(2'b01, 10'h150, 8'ha5, 8'hff);
    chk({fwd_rd_q, fwd_wr_q, 4'h0, fwd_space_q}, {2'b01, 4'h0, FWD_ETHERNET});
    chk(fwd_offset_q, 8'h10);
    chk(fwd_wdata_q, 8'ha5);
    expect_rd(2'b01, 10'h17f, 8'h43);
    chk({fwd_rd_q, fwd_wr_q, 4'h0, fwd_space_q}, {2'b10, 4'h0, FWD_ETHERNET});
    chk(fwd_offset_q, 8'h3f);
    expect_rd(2'b10, 10'h3ff, 8'hc3);
    for (int p = 0; p < 4; p++)
      foreach (XO[k])
      begin
        host.wr_reg(2'b10, {p[1:0], XO[k]}, 8'h5a, 8'hff);
        chk({fwd_wr_q, fwd_bert_q, fwd_port_q, 2'b00, fwd_space_q}, {1'b1, XB[k], p[1:0], 2'b00, FWD_XCVR});
        chk(fwd_offset_q, XO[k]);
      end
  endtask
  task automatic t_status();
    stat = 8'hff;
    expect_rd(2'b01, 10'h007, 8'h11);
    expect_rd(2'b01, 10'h009, 8'h01);
    expect_rd(2'b01, 10'h00b, 8'h11);
    expect_rd(2'b01, 10'h00d, 8'h03);
    expect_rd(2'b01, 10'h018, 8'hff);
    expect_rd(2'b01, 10'h021, 8'h03);
  endtask
  // clock enable low: no access is taken, no event is caught, nothing moves
  task automatic t_freeze();
    logic v;
    logic [7:0] d;
    // let one enabled edge pass so the last read's valid pulse has ended
    @(posedge ref_clk);
    #1;
    clk_en = 1'b0;
    host.wr_reg(2'b01, 10'h002, 8'h06, 8'h07);
    chk({5'h00, refclk_output_enable_q, interrupt_mask_bit_q, soft_reset_q}, 8'h00);
    host.rd_reg(2'b01, 10'h002, 8'hff, v, d);
    chk({7'h00, v}, 8'h00);
    pulse(8'h01, 1'b0, 8'h00);
    clk_en = 1'b1;
    expect_rd(2'b01, 10'h01a, 8'h00);
  endtask
  // a reset in mid-run clears the control bits and latched status
  task automatic t_reset();
    host.wr_reg(2'b01, 10'h002, 8'h06, 8'h07);
    pulse(8'h01, 1'b0, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    chk({5'h00, refclk_output_enable_q, interrupt_mask_bit_q, soft_reset_q}, 8'h00);
    expect_rd(2'b01, 10'h01a, 8'h00);
  endtask

  // ==========================================================
  // verdict, main sequence and hang guard
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    host.init_zero();
    t_ident();
    t_rw();
    t_ctrl();
    t_reserved();
    t_latched();
    t_fwd();
    t_status();
    t_freeze();
    t_reset();
    finish_test();
  end
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      finish_test();
    end
  end
endmodule // mapper_register_space_decode_tb_top
